// >>> sim/tlb_array_model.sv
`timescale 1ns/1ps
// Far-side entry store: keeps the last written entry and returns it on reads
module tlb_array_model (
   // Clock
   input wire logic mclk_in,
   // Write side
   input wire logic wr_in,
   input wire logic [63:0] lo_e_in,
   input wire logic [63:0] lo_o_in,
   input wire logic [11:0] mask_in,
   // Read side
   output logic [63:0] lo_e_out = 64'h0,
   output logic [63:0] lo_o_out = 64'h0,
   output logic [11:0] mask_out = 12'h0
);
   // One entry is enough: reads always follow the write under test
   always_ff @(posedge mclk_in)
   begin
      if (wr_in)
      begin
         lo_e_out <= lo_e_in;
         lo_o_out <= lo_o_in;
         mask_out <= mask_in;
      end
   end
endmodule

// >>> sim/tlb_control_registers_bench.sv
`timescale 1ns/1ps
module tlb_control_registers_bench;
   logic mclk_in = 1'h0, sys_rst_in = 1'h1, kern = 1'h1, retire = 1'h0, exc = 1'h0, hit = 1'h0;
   tlb_ctrl_pkg::sysctl_op_t op = tlb_ctrl_pkg::OP_NONE;
   logic [4:0] num = 5'h0;
   logic [2:0] sel = 3'h0;
   logic [63:0] wd = 64'h0, bva = 64'h0, rd, loe, loo, le, lo, a, cb, eh;
   logic [31:0] st = 32'h0, ctx;
   logic [5:0] pe = 6'h0, ent, w, p;
   logic [11:0] mk, tm;
   logic ux, wr, rq, pb, la;
   int n_errors = 0, checked = 0, t = 0;
   // Legal mask encodings, smallest page first
   localparam logic [11:0] SIZES [5] = '{tlb_ctrl_pkg::MASK_4K, tlb_ctrl_pkg::MASK_16K, tlb_ctrl_pkg::MASK_64K,
      tlb_ctrl_pkg::MASK_256K, tlb_ctrl_pkg::MASK_1M};
   always #12.5 mclk_in = ~mclk_in;
   tlb_control_registers i_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .op_in(op), .reg_num_in(num),
      .reg_sel_in(sel), .wdata_in(wd), .kernel_mode_in(kern), .status_in(st), .retire_in(retire),
      .tlb_exc_in(exc), .bad_vaddr_in(bva), .probe_hit_in(hit), .probe_entry_in(pe), .tlb_lo_even_in(le),
      .tlb_lo_odd_in(lo), .tlb_mask_in(tm), .tlb_hi_in(64'h0), .rdata_out(rd), .unusable_exc_out(ux),
      .tlb_wr_out(wr), .tlb_rd_out(rq), .tlb_probe_out(pb), .tlb_entry_out(ent), .lo_even_out(loe),
      .lo_odd_out(loo), .mask_out(mk), .entry_hi_out(eh), .context_out(ctx), .large_addr_out(la));
   tlb_array_model i_tlb (.mclk_in(mclk_in), .wr_in(wr), .lo_e_in(loe), .lo_o_in(loo), .mask_in(mk),
      .lo_e_out(le), .lo_o_out(lo), .mask_out(tm));
   // Compare and count
   task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One instruction, driven between falling edges
   task op1(input tlb_ctrl_pkg::sysctl_op_t o, input logic [4:0] n, input logic [2:0] s, input logic [63:0] d);
      @(negedge mclk_in);
      op = o;
      num = n;
      sel = s;
      wd = d;
      @(negedge mclk_in);
      op = tlb_ctrl_pkg::OP_NONE;
   endtask
   task rchk(input logic [4:0] n, input logic [2:0] s, input logic [63:0] e);
      op1(tlb_ctrl_pkg::OP_MOVE_FROM, n, s, 64'h0);
      chk("rdata", e, rd);
   endtask
   task done();
      t++;
      $display("test %0d finished", t);
   endtask
   // Pointer after one retire: reload at or below the fixed count
   function automatic logic [5:0] nx(input logic [5:0] q, input logic [5:0] f);
      return (q <= f || q == 6'h0) ? 6'h3F : q - 6'h1;
   endfunction
   task results();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      void'($urandom(32'h0B48AB5E));
      repeat (4) @(negedge mclk_in);
      sys_rst_in = 1'h0;
      rchk(5'h01, 3'h0, 64'h3F);
      rchk(5'h06, 3'h0, 64'h0);
      done();
      w = 6'($urandom_range(1, 40));
      op1(tlb_ctrl_pkg::OP_MOVE_TO, 5'h06, 3'h0, {58'h0, w});
      rchk(5'h01, 3'h0, 64'h3F);
      p = 6'h3F;
      @(negedge mclk_in);
      retire = 1'h1;
      repeat (70)
      begin
         @(negedge mclk_in);
         p = nx(p, w);
      end
      retire = 1'h0;
      rchk(5'h01, 3'h0, {58'h0, p});
      op1(tlb_ctrl_pkg::OP_TLB_WRITE_RND, 5'h0, 3'h0, 64'h0);
      chk("rnd entry", {58'h0, p}, {58'h0, ent});
      done();
      a = {$urandom, $urandom};
      op1(tlb_ctrl_pkg::OP_MOVE_TO, 5'h00, 3'h0, a);
      rchk(5'h00, 3'h0, {58'h0, a[5:0]});
      op1(tlb_ctrl_pkg::OP_TLB_WRITE_IDX, 5'h0, 3'h0, 64'h0);
      chk("idx entry", {58'h0, a[5:0]}, {58'h0, ent});
      op1(tlb_ctrl_pkg::OP_TLB_PROBE, 5'h0, 3'h0, 64'h0);
      rchk(5'h00, 3'h0, {32'h0, 1'h1, 25'h0, a[5:0]});
      hit = 1'h1;
      pe = 6'($urandom);
      op1(tlb_ctrl_pkg::OP_TLB_PROBE, 5'h0, 3'h0, 64'h0);
      rchk(5'h00, 3'h0, {58'h0, pe});
      done();
      for (int i = 0; i < 5; i++)
      begin
         a = {39'h0, SIZES[i], 13'h0};
         op1(tlb_ctrl_pkg::OP_MOVE_TO, 5'h05, 3'h0, a);
         rchk(5'h05, 3'h0, a);
      end
      chk("mask out", {52'h0, tlb_ctrl_pkg::MASK_1M}, {52'h0, mk});
      a = {$urandom, $urandom};
      cb = {$urandom, $urandom};
      op1(tlb_ctrl_pkg::OP_MOVE_TO, 5'h02, 3'h0, a);
      op1(tlb_ctrl_pkg::OP_MOVE_TO, 5'h03, 3'h0, cb);
      rchk(5'h03, 3'h0, cb);
      op1(tlb_ctrl_pkg::OP_TLB_WRITE_IDX, 5'h0, 3'h0, 64'h0);
      op1(tlb_ctrl_pkg::OP_MOVE_TO, 5'h02, 3'h0, ~a);
      op1(tlb_ctrl_pkg::OP_MOVE_TO, 5'h05, 3'h0, 64'h0);
      op1(tlb_ctrl_pkg::OP_TLB_READ, 5'h0, 3'h0, 64'h0);
      rchk(5'h02, 3'h0, a);
      rchk(5'h05, 3'h0, {39'h0, tlb_ctrl_pkg::MASK_1M, 13'h0});
      chk("odd low", cb, loo);
      done();
      kern = 1'h0;
      op1(tlb_ctrl_pkg::OP_MOVE_TO, 5'h00, 3'h0, 64'h3);
      chk("unusable", 64'h1, {63'h0, ux});
      st = 32'h10000000;
      rchk(5'h00, 3'h0, {58'h0, pe});
      kern = 1'h1;
      done();
      cb = {$urandom, $urandom} & 64'hFFFFFFFFFF800000;
      op1(tlb_ctrl_pkg::OP_MOVE_TO, 5'h04, 3'h0, cb);
      bva = {$urandom, $urandom};
      exc = 1'h1;
      @(negedge mclk_in);
      exc = 1'h0;
      rchk(5'h04, 3'h0, {cb[63:23], bva[31:13], 4'h0});
      chk("context", {32'h0, cb[31:23], bva[31:13], 4'h0}, {32'h0, ctx});
      op1(tlb_ctrl_pkg::OP_MOVE_TO, 5'h05, 3'h1, 64'hFFFFFFFFFFFFFFFF);
      rchk(5'h05, 3'h1, 64'h20000000);
      chk("large addr", 64'h1, {63'h0, la});
      rchk(5'h07, 3'h0, 64'h0);
      a = {$urandom, $urandom};
      op1(tlb_ctrl_pkg::OP_MOVE_TO, 5'h0A, 3'h0, a);
      rchk(5'h0A, 3'h0, a);
      chk("entry hi", a, eh);
      done();
      // Reset again in mid-run with a nonzero fixed count
      sys_rst_in = 1'h1;
      repeat (4) @(negedge mclk_in);
      sys_rst_in = 1'h0;
      rchk(5'h01, 3'h0, 64'h3F);
      rchk(5'h06, 3'h0, 64'h0);
      chk("even low", 64'h0, loe);
      done();
      results();
   end
endmodule

// >>> sim/tlb_control_registers_chk.sv
`timescale 1ns/1ps
module tlb_chk (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   // Instruction port
   input wire tlb_ctrl_pkg::sysctl_op_t op_in,
   input wire logic [4:0] reg_num_in,
   input wire logic [2:0] reg_sel_in,
   input wire logic [63:0] wdata_in,
   input wire logic kernel_mode_in,
   input wire logic [31:0] status_in,
   // Results
   input wire logic [63:0] rdata_out,
   input wire logic unusable_exc_out,
   input wire logic tlb_wr_out,
   input wire logic tlb_rd_out,
   input wire logic tlb_probe_out,
   input wire logic [63:0] lo_even_out
);
   // Privilege seen by the block on this edge
   logic pr;
   assign pr = op_in != tlb_ctrl_pkg::OP_NONE && (kernel_mode_in || status_in[tlb_ctrl_pkg::CU0_BIT]);
   default clocking @(posedge mclk_in);
   endclocking
   default disable iff (sys_rst_in);
   property p_exc; op_in != tlb_ctrl_pkg::OP_NONE && !pr |=> unusable_exc_out; endproperty
   a_exc: assert property (p_exc) else $error("missing unusable exception");
   property p_ok; pr |=> !unusable_exc_out; endproperty
   a_ok: assert property (p_ok) else $error("exception on permitted op");
   property p_quiet; !pr |=> !tlb_wr_out && !tlb_rd_out && !tlb_probe_out; endproperty
   a_quiet: assert property (p_quiet) else $error("strobe without permitted op");
   property p_wr; pr && (op_in == tlb_ctrl_pkg::OP_TLB_WRITE_IDX || op_in == tlb_ctrl_pkg::OP_TLB_WRITE_RND)
      |=> tlb_wr_out && !tlb_rd_out; endproperty
   a_wr: assert property (p_wr) else $error("write strobe missing");
   property p_rd; pr && op_in == tlb_ctrl_pkg::OP_TLB_READ |=> tlb_rd_out && !tlb_wr_out; endproperty
   a_rd: assert property (p_rd) else $error("read strobe missing");
   property p_pb; pr && op_in == tlb_ctrl_pkg::OP_TLB_PROBE |=> tlb_probe_out; endproperty
   a_pb: assert property (p_pb) else $error("probe strobe missing");
   property p_lo; pr && op_in == tlb_ctrl_pkg::OP_MOVE_TO && reg_num_in == 5'h02 && reg_sel_in == 3'h0
      |=> lo_even_out == $past(wdata_in); endproperty
   a_lo: assert property (p_lo) else $error("even low entry not written");
   property p_hold; !(pr && op_in == tlb_ctrl_pkg::OP_MOVE_FROM) |=> $stable(rdata_out); endproperty
   a_hold: assert property (p_hold) else $error("read data changed without move-from");
endmodule
bind tlb_control_registers tlb_chk i_chk (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .op_in(op_in),
   .reg_num_in(reg_num_in), .reg_sel_in(reg_sel_in), .wdata_in(wdata_in), .kernel_mode_in(kernel_mode_in),
   .status_in(status_in), .rdata_out(rdata_out), .unusable_exc_out(unusable_exc_out),
   .tlb_wr_out(tlb_wr_out), .tlb_rd_out(tlb_rd_out), .tlb_probe_out(tlb_probe_out),
   .lo_even_out(lo_even_out));

// >>> verilog/tlb_control_registers.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Registers reached only by move-from and move-to coprocessor instructions.
// - Kernel mode or usable bit 28 permits access; otherwise unavailable exception.
// - Index 0/0, random 1/0, even low 2/0, odd low 3/0, context 4/0.
// - Page mask 5/0, large-address 5/1, fixed count 6/0, upper entry 10/0.
// - Index register is 32 bits; low six bits select an entry.
// - Top index bit set when the last probe found no match.
// - Index field gives the entry for TLB read and indexed write.
// - Reserved fields read as zero; software writes them as zero.
// - Random pointer is read-only and decrements after each instruction.
// - Random pointer stays between fixed count and entry count minus one.
// - Random write targets the current random pointer.
// - Random pointer loads its upper bound at restart.
// - Writing the fixed count reloads the random pointer to the top.
// - Even and odd low-entry registers, same format, exchanged on TLB access.
// - TLB exception loads the 19-bit page-pair field with address bits 31:13.
// - Context value directly addresses 8-byte paired entries for 4K pages.
// - Page mask is the source for TLB writes, destination for reads.
// - Each entry's mask decides which address bits 24:13 are compared.
// - Mask holds one of the encoded page sizes; others are undefined.
// - Fixed-entry count clears to zero at reset.
module tlb_control_registers #(
   parameter int IDX_W = 6,
   parameter logic [5:0] TLB_TOP = 6'h3F
)
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   // Pipeline instruction port
   input wire tlb_ctrl_pkg::sysctl_op_t op_in,
   input wire logic [4:0] reg_num_in,
   input wire logic [2:0] reg_sel_in,
   input wire logic [63:0] wdata_in,
   input wire logic kernel_mode_in,
   input wire logic [31:0] status_in,
   input wire logic retire_in,
   // Exception capture
   input wire logic tlb_exc_in,
   input wire logic [63:0] bad_vaddr_in,
   // TLB array side
   input wire logic probe_hit_in,
   input wire logic [IDX_W-1:0] probe_entry_in,
   input wire logic [63:0] tlb_lo_even_in,
   input wire logic [63:0] tlb_lo_odd_in,
   input wire logic [11:0] tlb_mask_in,
   input wire logic [63:0] tlb_hi_in,
   // Results
   output logic [63:0] rdata_out,
   output logic unusable_exc_out,
   output logic tlb_wr_out,
   output logic tlb_rd_out,
   output logic tlb_probe_out,
   output logic [IDX_W-1:0] tlb_entry_out,
   output logic [63:0] lo_even_out,
   output logic [63:0] lo_odd_out,
   output logic [11:0] mask_out,
   output logic [63:0] entry_hi_out,
   output logic [31:0] context_out,
   output logic large_addr_out
);
   logic allowed;
   logic is_mtc;
   logic is_tlb_read_instr;
   logic is_mfc;
   logic is_probe;
   logic is_tlbw;
   logic sel0;
   logic wr_index;
   logic wr_lo_even;
   logic wr_lo_odd;
   logic wr_ctx;
   logic wr_mask;
   logic wr_grain;
   logic wr_hi;
   logic wired_wr;
   logic probe_fail_q;
   logic [IDX_W-1:0] index_q;
   logic [IDX_W-1:0] wired_q;
   logic [IDX_W-1:0] random_ptr;
   logic [tlb_ctrl_pkg::PAIR_W-1:0] pair_q;
   logic [63:tlb_ctrl_pkg::BASE_POS] base_q;
   logic [11:0] mask_q;
   logic [63:0] rdata_d;

   // Privilege check for every coprocessor instruction
   assign allowed = kernel_mode_in || status_in[tlb_ctrl_pkg::CU0_BIT];
   assign is_mtc = allowed && op_in == tlb_ctrl_pkg::OP_MOVE_TO;
   assign is_tlb_read_instr = allowed && op_in == tlb_ctrl_pkg::OP_TLB_READ;
   assign wired_wr = is_mtc && reg_num_in == tlb_ctrl_pkg::REG_WIRED && reg_sel_in == tlb_ctrl_pkg::SEL_0;

   // One decoded enable per register; unmapped numbers enable nothing
   assign sel0 = reg_sel_in == tlb_ctrl_pkg::SEL_0;
   assign is_mfc = allowed && op_in == tlb_ctrl_pkg::OP_MOVE_FROM;
   assign is_probe = allowed && op_in == tlb_ctrl_pkg::OP_TLB_PROBE;
   assign is_tlbw = allowed && (op_in == tlb_ctrl_pkg::OP_TLB_WRITE_IDX || op_in == tlb_ctrl_pkg::OP_TLB_WRITE_RND);
   assign wr_index = is_mtc && sel0 && reg_num_in == tlb_ctrl_pkg::REG_INDEX;
   assign wr_lo_even = is_mtc && sel0 && reg_num_in == tlb_ctrl_pkg::REG_LO_EVEN;
   assign wr_lo_odd = is_mtc && sel0 && reg_num_in == tlb_ctrl_pkg::REG_LO_ODD;
   assign wr_ctx = is_mtc && sel0 && reg_num_in == tlb_ctrl_pkg::REG_CONTEXT;
   assign wr_mask = is_mtc && sel0 && reg_num_in == tlb_ctrl_pkg::REG_PAGE_SIZE_MASK_REGISTER;
   assign wr_grain = is_mtc && reg_sel_in == tlb_ctrl_pkg::SEL_1 && reg_num_in == tlb_ctrl_pkg::REG_PAGE_SIZE_MASK_REGISTER;
   assign wr_hi = is_mtc && sel0 && reg_num_in == tlb_ctrl_pkg::REG_ENTRY_HI;

   tlb_random_ptr #(
      .IDX_W(IDX_W),
      .TOP(TLB_TOP)
   ) u_random (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .retire_in(retire_in),
      .wired_wr_in(wired_wr),
      .wired_in(wired_q),
      .ptr_out(random_ptr)
   );

   // Exception flag for disallowed access
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         unusable_exc_out <= 1'b0;
      else
         unusable_exc_out <= !allowed && op_in != tlb_ctrl_pkg::OP_NONE;
   end

   // Index register: written by software, updated by probe
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         index_q <= '0;
         probe_fail_q <= 1'b0;
      end
      else if (is_probe)
      begin
         probe_fail_q <= !probe_hit_in;
         if (probe_hit_in)
            index_q <= probe_entry_in;
      end
      else if (wr_index)
         index_q <= wdata_in[IDX_W-1:0];
   end

   // Fixed-entry count
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         wired_q <= tlb_ctrl_pkg::WIRED_RESET;
      else if (wired_wr)
         wired_q <= wdata_in[IDX_W-1:0];
   end

   // Low entries: software writes or TLB read loads
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         lo_even_out <= tlb_ctrl_pkg::ZERO64;
         lo_odd_out <= tlb_ctrl_pkg::ZERO64;
      end
      else if (is_tlb_read_instr)
      begin
         lo_even_out <= tlb_lo_even_in;
         lo_odd_out <= tlb_lo_odd_in;
      end
      else
      begin
         if (wr_lo_even)
            lo_even_out <= wdata_in;
         if (wr_lo_odd)
            lo_odd_out <= wdata_in;
      end
   end

   // Upper entry half; a TLB read reloads it from the array
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         entry_hi_out <= tlb_ctrl_pkg::ZERO64;
      else if (is_tlb_read_instr)
         entry_hi_out <= tlb_hi_in;
      else if (wr_hi)
         entry_hi_out <= wdata_in;
   end

   // Page mask; only the mask field is kept so reserved bits read zero
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         mask_q <= tlb_ctrl_pkg::MASK_4K;
      else if (is_tlb_read_instr)
         mask_q <= tlb_mask_in;
      else if (wr_mask)
         mask_q <= wdata_in[tlb_ctrl_pkg::MASK_LSB +: tlb_ctrl_pkg::MASK_W];
   end

   // Large-address control
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         large_addr_out <= 1'b0;
      else if (wr_grain)
         large_addr_out <= wdata_in[tlb_ctrl_pkg::LARGE_ADDR_BIT];
   end

   // Context base, written by software only
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         base_q <= '0;
      else if (wr_ctx)
         base_q <= wdata_in[63:tlb_ctrl_pkg::BASE_POS];
   end

   // Page pair in its own process so a fault is never lost to a move-to
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         pair_q <= '0;
      else if (tlb_exc_in)
         pair_q <= bad_vaddr_in[tlb_ctrl_pkg::PAIR_MSB:tlb_ctrl_pkg::PAIR_LSB];
   end

   // Context formatted as base, pair number, then 4 zero bits (pairs of 8-byte entries)
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         context_out <= '0;
      else
         context_out <= {base_q[31:tlb_ctrl_pkg::BASE_POS], pair_q, {tlb_ctrl_pkg::PAIR_POS{1'b0}}};
   end

   // TLB command strobes, one cycle each
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         tlb_wr_out <= 1'b0;
         tlb_rd_out <= 1'b0;
         tlb_probe_out <= 1'b0;
      end
      else
      begin
         tlb_wr_out <= is_tlbw;
         tlb_rd_out <= is_tlb_read_instr;
         tlb_probe_out <= is_probe;
      end
   end

   // Target entry launched together with the write strobe
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         tlb_entry_out <= '0;
      else if (op_in == tlb_ctrl_pkg::OP_TLB_WRITE_RND)
         tlb_entry_out <= random_ptr;
      else
         tlb_entry_out <= index_q;
   end

   // Mask copy for the array; lags the register by one cycle
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         mask_out <= tlb_ctrl_pkg::MASK_4K;
      else
         mask_out <= mask_q;
   end

   // Read mux; reserved bits and unmapped registers return zero
   always_comb
   begin
      rdata_d = tlb_ctrl_pkg::ZERO64;
      if (reg_sel_in == tlb_ctrl_pkg::SEL_0)
      begin
         case (reg_num_in)
            tlb_ctrl_pkg::REG_INDEX:
            begin
               rdata_d[tlb_ctrl_pkg::PROBE_FAIL_BIT] = probe_fail_q;
               rdata_d[IDX_W-1:0] = index_q;
            end
            tlb_ctrl_pkg::REG_RANDOM: rdata_d[IDX_W-1:0] = random_ptr;
            tlb_ctrl_pkg::REG_LO_EVEN: rdata_d = lo_even_out;
            tlb_ctrl_pkg::REG_LO_ODD: rdata_d = lo_odd_out;
            tlb_ctrl_pkg::REG_CONTEXT:
               rdata_d = {base_q, pair_q, {tlb_ctrl_pkg::PAIR_POS{1'b0}}};
            tlb_ctrl_pkg::REG_PAGE_SIZE_MASK_REGISTER: rdata_d[tlb_ctrl_pkg::MASK_LSB +: tlb_ctrl_pkg::MASK_W] = mask_q;
            tlb_ctrl_pkg::REG_WIRED: rdata_d[IDX_W-1:0] = wired_q;
            tlb_ctrl_pkg::REG_ENTRY_HI: rdata_d = entry_hi_out;
            default: rdata_d = tlb_ctrl_pkg::ZERO64;
         endcase
      end
      else if (reg_sel_in == tlb_ctrl_pkg::SEL_1 && reg_num_in == tlb_ctrl_pkg::REG_PAGE_SIZE_MASK_REGISTER)
         rdata_d[tlb_ctrl_pkg::LARGE_ADDR_BIT] = large_addr_out;
   end

   // Read data registered, only on a permitted move-from
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         rdata_out <= tlb_ctrl_pkg::ZERO64;
      else if (is_mfc)
         rdata_out <= rdata_d;
   end
endmodule

// >>> verilog/tlb_ctrl_pkg.sv
package tlb_ctrl_pkg;
   // Register numbers and selects
   localparam logic [4:0] REG_INDEX = 5'h00;
   localparam logic [4:0] REG_RANDOM = 5'h01;
   localparam logic [4:0] REG_LO_EVEN = 5'h02;
   localparam logic [4:0] REG_LO_ODD = 5'h03;
   localparam logic [4:0] REG_CONTEXT = 5'h04;
   localparam logic [4:0] REG_PAGE_SIZE_MASK_REGISTER = 5'h05;
   localparam logic [4:0] REG_WIRED = 5'h06;
   localparam logic [4:0] REG_ENTRY_HI = 5'h0A;
   localparam logic [2:0] SEL_0 = 3'h0;
   localparam logic [2:0] SEL_1 = 3'h1;
   // Field layout
   localparam int TLB_IDX_W = 6;
   localparam int PROBE_FAIL_BIT = 31;
   localparam int CU0_BIT = 28;
   localparam int PAIR_LSB = 13;
   localparam int PAIR_MSB = 31;
   localparam int PAIR_W = 19;
   localparam int PAIR_POS = 4;
   localparam int BASE_POS = 23;
   localparam int MASK_LSB = 13;
   localparam int MASK_W = 12;
   localparam int LARGE_ADDR_BIT = 29;
   // Legal page mask encodings, bits 24:13
   localparam logic [11:0] MASK_4K = 12'h000;
   localparam logic [11:0] MASK_16K = 12'h003;
   localparam logic [11:0] MASK_64K = 12'h00F;
   localparam logic [11:0] MASK_256K = 12'h03F;
   localparam logic [11:0] MASK_1M = 12'h0FF;
   // Reset values
   localparam logic [5:0] WIRED_RESET = 6'h00;
   localparam logic [63:0] ZERO64 = 64'h0000000000000000;
   // Instruction codes from the pipeline
   typedef enum logic [2:0]
   {
      OP_NONE = 3'b000,
      OP_MOVE_FROM = 3'b001,
      OP_MOVE_TO = 3'b010,
      OP_TLB_PROBE = 3'b011,
      OP_TLB_READ = 3'b100,
      OP_TLB_WRITE_IDX = 3'b101,
      OP_TLB_WRITE_RND = 3'b110
   } sysctl_op_t;
endpackage

// >>> verilog/tlb_random_ptr.sv
`timescale 1ns/1ps
// Replacement pointer that walks down between the fixed-entry count and the top entry
module tlb_random_ptr #(
   parameter int IDX_W = 6,
   parameter logic [5:0] TOP = 6'h3F
)
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   // Control
   input wire logic retire_in,
   input wire logic wired_wr_in,
   input wire logic [IDX_W-1:0] wired_in,
   // Pointer
   output logic [IDX_W-1:0] ptr_out
);
   // Decrement per retired instruction, wrap to the top at the floor
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         ptr_out <= TOP;
      else if (wired_wr_in)
         ptr_out <= TOP;
      else if (retire_in)
      begin
         if (ptr_out <= wired_in || ptr_out == '0)
            ptr_out <= TOP;
         else
            ptr_out <= ptr_out - IDX_W'(1);
      end
   end
endmodule
